// >>> hdl/ebpm_cfg_regs.sv
// Configuration register slave for the external bus pin multiplexer
`timescale 1ns/100ps
`include "ebpm_consts.svh"
module ebpm_cfg_regs (
	input  wire logic                 sys_clk,
	input  wire logic                 resetn,
	input  wire logic [11:0]          reg_addr,
	input  wire ebpm_pkg::ebpm_data_t reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output ebpm_pkg::ebpm_data_t      reg_rdata,
	output ebpm_pkg::ebpm_data_t      cfg
);
	import ebpm_pkg::*;

	// Register store; reserved bits are masked off
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cfg <= `EBPM_CFG_RESET;
		end else if (reg_wr && reg_addr == `EBPM_CFG_OFFSET) begin
			cfg <= reg_wdata & `EBPM_CFG_MASK;
		end
	end

	// Read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd && reg_addr == `EBPM_CFG_OFFSET) begin
			reg_rdata <= cfg;
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	AST_RESET_VALUE: assert property (@(posedge sys_clk)
		$rose(resetn) |-> cfg == `EBPM_CFG_RESET)
		else $error("config not at reset value");
	AST_RESERVED_ZERO: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		(cfg & ~`EBPM_CFG_MASK) == 32'h00000000)
		else $error("reserved config bits set");
endmodule

// >>> hdl/ebpm_consts.svh
// Constants for the external bus pin multiplexer
`ifndef EBPM_CONSTS_SVH
`define EBPM_CONSTS_SVH
`define EBPM_CFG_OFFSET     12'h11C
`define EBPM_CFG_RESET      32'h00010000
`define EBPM_CFG_MASK       32'h0001013A
`define EBPM_BIT_CS1        1
`define EBPM_BIT_CS3        3
`define EBPM_BIT_CS4        4
`define EBPM_BIT_CS5        5
`define EBPM_BIT_PUC        8
`define EBPM_BIT_VSEL       16
`define EBPM_CS1            1
`define EBPM_CS3            3
`define EBPM_CS4            4
`define EBPM_CS5            5
`define EBPM_ADDR_W         26
`define EBPM_CS_W           8
`define EBPM_DATA_W         32
`define EBPM_SD_ADDR_W      13
`define EBPM_SD_A10         10
`endif

// >>> hdl/ebpm_pin_mux.sv
// Pin multiplexer for the shared external memory bus
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
`include "ebpm_consts.svh"
module ebpm_pin_mux (
	input  wire logic                 sys_clk,
	input  wire logic                 resetn,
	input  wire logic [11:0]          reg_addr,
	input  wire ebpm_pkg::ebpm_data_t reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output ebpm_pkg::ebpm_data_t      reg_rdata,
	input  wire ebpm_pkg::ebpm_addr_t smc_addr,
	input  wire ebpm_pkg::ebpm_cs_t   smc_cs_n,
	input  wire logic                 smc_busy,
	input  wire ebpm_pkg::ebpm_data_t smc_wdata,
	input  wire logic                 smc_data_oe,
	input  wire logic                 smc_bus16,
	input  wire logic [12:0]          sdram_addr,
	input  wire logic                 sdram_cs_n,
	input  wire logic                 sdram_busy,
	input  wire ebpm_pkg::ebpm_data_t sdram_wdata,
	input  wire logic                 sdram_data_oe,
	input  wire ebpm_pkg::ebpm_data_t ext_data_in,
	input  wire logic                 external_wait_in_n,
	output ebpm_pkg::ebpm_addr_t      ext_addr,
	output ebpm_pkg::ebpm_cs_t        chip_select_lines_n,
	output logic                      sdram_addr10_pin,
	output ebpm_pkg::ebpm_data_t      ext_data_out,
	output logic [31:0]               ext_data_oe,
	output ebpm_pkg::ebpm_data_t      ctrl_rdata,
	output logic                      ctrl_wait_n,
	output logic                      nand_logic_active,
	output logic                      card_slot0_active,
	output logic                      card_slot1_active,
	output logic                      data_pullup_en,
	output logic                      memory_voltage_select
);
	import ebpm_pkg::*;

	ebpm_data_t  cfg;
	ebpm_owner_e owner;
	ebpm_owner_e next_owner;
	logic        cs1_owner_select;
	logic        cs1_lat;
	logic        wait_meta;
	logic        wait_sync;
	ebpm_data_t  din_meta;
	ebpm_data_t  din_sync;

	ebpm_cfg_regs u_regs (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata),
		.cfg       (cfg)
	);

	// Build the SDRAM view of the 26 address pins
	function automatic ebpm_addr_t sd_addr_map(input logic [12:0] a);
		ebpm_addr_t r;
		r = '0;
		r[11:2]  = a[9:0];
		r[14:13] = a[12:11];
		return r;
	endfunction

	assign cs1_owner_select = cfg[`EBPM_BIT_CS1];

	// Owner arbitration: SDRAM if busy and given select 1; else static if busy; idle otherwise
	always_comb begin
		next_owner = EBPM_OWN_IDLE;
		if (sdram_busy && cs1_owner_select) begin
			next_owner = EBPM_OWN_SDRAM;
		end else if (smc_busy) begin
			next_owner = EBPM_OWN_STATIC;
		end
	end

	// Owner held for the length of an access
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			owner <= EBPM_OWN_IDLE;
		end else begin
			case (owner)
				EBPM_OWN_IDLE: owner <= next_owner;
				EBPM_OWN_STATIC: begin
					if (!smc_busy) begin
						owner <= next_owner;
					end
				end
				EBPM_OWN_SDRAM: begin
					if (!sdram_busy) begin
						owner <= next_owner;
					end
				end
				default: owner <= EBPM_OWN_IDLE;
			endcase
		end
	end

	// CS1 owner latched between accesses so a write never cuts one short
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cs1_lat <= 1'b0;
		end else if (!smc_busy && !sdram_busy) begin
			cs1_lat <= cs1_owner_select;
		end
	end

	// Glue enables and pad controls; registered so outputs come from flops
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			nand_logic_active     <= 1'b0;
			card_slot0_active     <= 1'b0;
			card_slot1_active     <= 1'b0;
			data_pullup_en        <= 1'b1;
			memory_voltage_select <= 1'b1;
		end else begin
			if (!smc_busy) begin
				nand_logic_active <= cfg[`EBPM_BIT_CS3];
				card_slot0_active <= cfg[`EBPM_BIT_CS4];
				card_slot1_active <= cfg[`EBPM_BIT_CS5];
			end
			data_pullup_en        <= ~cfg[`EBPM_BIT_PUC];
			memory_voltage_select <= cfg[`EBPM_BIT_VSEL];
		end
	end

	// Pin synchronisers for wait and data inputs
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wait_meta <= 1'b1;
			wait_sync <= 1'b1;
			din_meta  <= '0;
			din_sync  <= '0;
		end else begin
			wait_meta <= external_wait_in_n;
			wait_sync <= wait_meta;
			din_meta  <= ext_data_in;
			din_sync  <= din_meta;
		end
	end

	// Address and data pins by owner; chip selects from the static controller, CS1 by latched owner
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ext_addr            <= '0;
			chip_select_lines_n <= '1;
			sdram_addr10_pin    <= 1'b0;
			ext_data_out        <= '0;
			ext_data_oe         <= '0;
		end else begin
			chip_select_lines_n <= smc_cs_n;
			// CS1 belongs to one controller only; others stay static
			chip_select_lines_n[`EBPM_CS1] <= cs1_lat ?
				sdram_cs_n : smc_cs_n[`EBPM_CS1];
			case (owner)
				EBPM_OWN_SDRAM: begin
					ext_addr         <= sd_addr_map(sdram_addr);
					sdram_addr10_pin <= sdram_addr[`EBPM_SD_A10];
					ext_data_out     <= sdram_wdata;
					ext_data_oe      <= {32{sdram_data_oe}};
				end
				EBPM_OWN_STATIC: begin
					ext_addr         <= smc_addr;
					sdram_addr10_pin <= 1'b0;
					ext_data_out     <= smc_wdata;
					// Narrow bus leaves the upper half undriven
					ext_data_oe      <= {{16{smc_data_oe & ~smc_bus16}},
						{16{smc_data_oe}}};
				end
				default: begin
					ext_addr         <= ext_addr;
					sdram_addr10_pin <= sdram_addr10_pin;
					ext_data_out     <= ext_data_out;
					ext_data_oe      <= '0;
				end
			endcase
		end
	end

	// Read data and wait back to the controllers
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_rdata  <= '0;
			ctrl_wait_n <= 1'b1;
		end else begin
			ctrl_rdata  <= din_sync;
			ctrl_wait_n <= wait_sync;
		end
	end

	// Eight address spaces need eight owned selects; selects 0..7 reach pins
	// unchanged except select 1, which the register may hand to SDRAM

	sequence s_sd_active;
		owner == EBPM_OWN_SDRAM;
	endsequence
	sequence s_sd_pins;
		ext_addr[11:2] == $past(sdram_addr[9:0]) &&
		sdram_addr10_pin == $past(sdram_addr[`EBPM_SD_A10]);
	endsequence

	sequence s_st_active;
		owner == EBPM_OWN_STATIC;
	endsequence
	sequence s_idle;
		owner == EBPM_OWN_IDLE;
	endsequence
	sequence s_sd_high;
		ext_addr[14:13] == $past(sdram_addr[12:11]) && !ext_addr[12];
	endsequence
	// Three edges out of reset, so the input syncs hold live samples
	sequence s_settled;
		resetn && $past(resetn) && $past(resetn, 2);
	endsequence

	// Selects trail their source by one edge
	AST_CS1_SDRAM: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		cs1_lat |=> chip_select_lines_n[`EBPM_CS1] == $past(sdram_cs_n))
		else $error("cs1 not from sdram");
	AST_CS1_STATIC: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		!cs1_lat |=> chip_select_lines_n[`EBPM_CS1] ==
			$past(smc_cs_n[`EBPM_CS1]))
		else $error("cs1 not from static");
	AST_CS3_STATIC: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		1'b1 |=> chip_select_lines_n[`EBPM_CS3] ==
			$past(smc_cs_n[`EBPM_CS3]))
		else $error("cs3 not static");
	AST_CS_PASS: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		1'b1 |=> chip_select_lines_n[7:2] == $past(smc_cs_n[7:2]) &&
			chip_select_lines_n[0] == $past(smc_cs_n[0]))
		else $error("static selects not passed through");

	// Glue enables wait for an idle static controller; pads follow at once
	AST_NAND_EN: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		!smc_busy |=> nand_logic_active == $past(cfg[`EBPM_BIT_CS3]))
		else $error("nand enable wrong");
	AST_SLOT0: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		!smc_busy |=> card_slot0_active == $past(cfg[`EBPM_BIT_CS4]))
		else $error("slot0 enable wrong");
	AST_SLOT1: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		!smc_busy |=> card_slot1_active == $past(cfg[`EBPM_BIT_CS5]))
		else $error("slot1 enable wrong");
	AST_PULLUP: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		1'b1 |=> data_pullup_en != $past(cfg[`EBPM_BIT_PUC]))
		else $error("pullup wrong");
	AST_VSEL: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		1'b1 |=> memory_voltage_select == $past(cfg[`EBPM_BIT_VSEL]))
		else $error("voltage select wrong");

	// Address, data and enables by owner, one edge after the choice
	AST_SD_ADDR: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		s_sd_active |=> s_sd_pins)
		else $error("sdram address pins wrong");
	AST_SD_HIGH: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		s_sd_active |=> s_sd_high)
		else $error("sdram upper address pins wrong");
	AST_ST_ADDR: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		s_st_active |=> ext_addr == $past(smc_addr))
		else $error("static address wrong");
	AST_IDLE_HOLD: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		s_idle |=> $stable(ext_addr))
		else $error("idle address not held");
	AST_SD_OE: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		s_sd_active |=> ext_data_oe == {32{$past(sdram_data_oe)}})
		else $error("sdram data enable wrong");
	AST_ST_OE: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		s_st_active |=> ext_data_oe[15:0] == {16{$past(smc_data_oe)}} &&
			ext_data_oe[31:16] ==
			{16{$past(smc_data_oe) & ~$past(smc_bus16)}})
		else $error("static data enable wrong");
	AST_IDLE_OE: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		s_idle |=> ext_data_oe == 32'h00000000)
		else $error("idle data bus driven");
	AST_SD_DATA: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		s_sd_active |=> ext_data_out == $past(sdram_wdata))
		else $error("sdram write data wrong");
	AST_ST_DATA: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		s_st_active |=> ext_data_out == $past(smc_wdata))
		else $error("static write data wrong");

	// Pin inputs reach the controllers three edges late
	AST_RDATA_PIPE: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		s_settled |=> ctrl_rdata == $past(ext_data_in, 3))
		else $error("read data path delay wrong");
	AST_WAIT_PIPE: assert property (@(posedge sys_clk)
		disable iff (!resetn)
		s_settled |=> ctrl_wait_n == $past(external_wait_in_n, 3))
		else $error("wait path delay wrong");
endmodule

// >>> hdl/ebpm_pkg.sv
// Types for the external bus pin multiplexer
`include "ebpm_consts.svh"
package ebpm_pkg;
	typedef enum logic [1:0] {
		EBPM_OWN_IDLE,
		EBPM_OWN_STATIC,
		EBPM_OWN_SDRAM
	} ebpm_owner_e;
	typedef logic [`EBPM_ADDR_W-1:0] ebpm_addr_t;
	typedef logic [`EBPM_CS_W-1:0]   ebpm_cs_t;
	typedef logic [`EBPM_DATA_W-1:0] ebpm_data_t;
endpackage

// >>> tb/ebpm_mem_model.sv
// Behavioural external memory sitting on the shared bus pins
`timescale 1ns/100ps
module ebpm_mem_model (
	input  wire logic                 sys_clk,
	input  wire ebpm_pkg::ebpm_addr_t ext_addr,
	input  wire ebpm_pkg::ebpm_cs_t   chip_select_lines_n,
	input  wire logic                 data_pullup_en,
	output ebpm_pkg::ebpm_data_t      ext_data_in,
	output logic                      external_wait_in_n
);
	import ebpm_pkg::*;
	ebpm_data_t last = 32'h00000000;
	// Selected device answers with its address under a fixed pattern
	// Released lines float, so the low half pulls up or keeps inverting
	always @(posedge sys_clk) begin
		if (&chip_select_lines_n) begin
			last <= {~last[31:16], data_pullup_en ? 16'hFFFF : ~last[15:0]};
		end else begin
			last <= {6'h00, ext_addr} ^ 32'hA5000000;
		end
	end
	assign ext_data_in = last;
	// Device behind select 0 is slow and holds wait low while selected
	assign external_wait_in_n = chip_select_lines_n[0];
endmodule

// >>> tb/ebpm_pin_mux_tb_top.sv
// Self-checking bench for the external bus pin multiplexer
`timescale 1ns/100ps
`include "ebpm_consts.svh"
module ebpm_pin_mux_tb_top;
	import ebpm_pkg::*;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	ebpm_data_t  reg_wdata = 32'h0, smc_wdata = 32'h0, sdram_wdata = 32'h0;
	ebpm_addr_t  smc_addr = 26'h0;
	ebpm_cs_t    smc_cs_n = 8'hFF;
	logic        smc_busy = 1'b0, smc_data_oe = 1'b0, smc_bus16 = 1'b0;
	logic [12:0] sdram_addr = 13'h0;
	logic        sdram_cs_n = 1'b1, sdram_busy = 1'b0, sdram_data_oe = 1'b0;
	ebpm_data_t  reg_rdata, ext_data_in, ext_data_out, ctrl_rdata;
	ebpm_addr_t  ext_addr;
	ebpm_cs_t    chip_select_lines_n;
	logic [31:0] ext_data_oe;
	logic        external_wait_in_n, sdram_addr10_pin, ctrl_wait_n;
	logic        nand_logic_active, card_slot0_active, card_slot1_active;
	logic        data_pullup_en, memory_voltage_select;
	int          err_count = 0;
	int          cmp_count = 0;
	localparam logic [11:0] OFS = `EBPM_CFG_OFFSET;

	always #20 sys_clk = ~sys_clk;

	ebpm_pin_mux dut (.sys_clk(sys_clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .smc_addr(smc_addr),
		.smc_cs_n(smc_cs_n), .smc_busy(smc_busy), .smc_wdata(smc_wdata),
		.smc_data_oe(smc_data_oe), .smc_bus16(smc_bus16),
		.sdram_addr(sdram_addr), .sdram_cs_n(sdram_cs_n),
		.sdram_busy(sdram_busy), .sdram_wdata(sdram_wdata),
		.sdram_data_oe(sdram_data_oe), .ext_data_in(ext_data_in),
		.external_wait_in_n(external_wait_in_n), .ext_addr(ext_addr),
		.chip_select_lines_n(chip_select_lines_n),
		.sdram_addr10_pin(sdram_addr10_pin), .ext_data_out(ext_data_out),
		.ext_data_oe(ext_data_oe), .ctrl_rdata(ctrl_rdata),
		.ctrl_wait_n(ctrl_wait_n), .nand_logic_active(nand_logic_active),
		.card_slot0_active(card_slot0_active),
		.card_slot1_active(card_slot1_active),
		.data_pullup_en(data_pullup_en),
		.memory_voltage_select(memory_voltage_select));

	ebpm_mem_model mem (.sys_clk(sys_clk), .ext_addr(ext_addr),
		.chip_select_lines_n(chip_select_lines_n),
		.data_pullup_en(data_pullup_en), .ext_data_in(ext_data_in),
		.external_wait_in_n(external_wait_in_n));

	// Single comparison point, four-state exact
	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic reg_write(input logic [11:0] a, input ebpm_data_t d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [11:0] a, input ebpm_data_t e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", e, reg_rdata);
	endtask

	// Fixed settle: pins trail the owner choice by two edges plus syncs
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic test_done();
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Whole run is under a hundred cycles; this cuts a hang short at 3000
	initial begin
		#(40 * 3000);
		err_count++;
		test_done();
	end

	initial begin
		repeat (10) @(posedge sys_clk);
		resetn <= 1'b1;
		reg_read(OFS, `EBPM_CFG_RESET);
		chk("pads", 2'b11,
			{data_pullup_en, memory_voltage_select});
		reg_write(OFS, 32'hFFFFFFFF);
		reg_write(12'h120, 32'h00000000);
		reg_read(OFS, `EBPM_CFG_MASK);
		reg_read(12'h118, 32'h0);
		wait_cyc(3);
		chk("glue", 3'b111, {nand_logic_active, card_slot0_active,
			card_slot1_active});
		chk("pads", 2'b01,
			{data_pullup_en, memory_voltage_select});
		reg_write(OFS, 32'h00000000);
		wait_cyc(3);
		chk("pads", 2'b10,
			{data_pullup_en, memory_voltage_select});
		chk("glue", 3'b000, {nand_logic_active, card_slot0_active,
			card_slot1_active});
		// Static access; SDRAM busy too but select 1 not handed to it
		@(posedge sys_clk);
		smc_busy <= 1'b1;
		smc_addr <= 26'h2ABCDEF;
		smc_cs_n <= 8'hFE;
		smc_wdata <= 32'h13579BDF;
		smc_data_oe <= 1'b1;
		smc_bus16 <= 1'b1;
		sdram_busy <= 1'b1;
		sdram_cs_n <= 1'b0;
		reg_write(OFS, 32'h00000008);
		wait_cyc(10);
		chk("ext_addr", 32'h2ABCDEF, ext_addr);
		chk("cs", 8'hFE, chip_select_lines_n);
		chk("oe", 32'h0000FFFF, ext_data_oe);
		chk("dout", 32'h13579BDF, ext_data_out);
		chk("wait", 1'b0, ctrl_wait_n);
		chk("rdata", 32'hA5000000 ^ 32'h2ABCDEF, ctrl_rdata);
		chk("nand", 1'b0, nand_logic_active);
		@(posedge sys_clk);
		smc_bus16 <= 1'b0;
		wait_cyc(3);
		chk("oe", 32'hFFFFFFFF, ext_data_oe);
		@(posedge sys_clk);
		smc_busy <= 1'b0;
		sdram_busy <= 1'b0;
		smc_cs_n <= 8'hFF;
		wait_cyc(4);
		chk("nand", 1'b1, nand_logic_active);
		chk("oe", 32'h00000000, ext_data_oe);
		// SDRAM access once select 1 belongs to it
		reg_write(OFS, 32'h00000002);
		wait_cyc(3);
		@(posedge sys_clk);
		sdram_addr <= 13'h1D5A;
		sdram_wdata <= 32'h9ABCDEF0;
		sdram_data_oe <= 1'b1;
		sdram_busy <= 1'b1;
		wait_cyc(5);
		chk("ext_addr", {11'h0, 2'b11, 1'b0, 10'h15A, 2'b00}, ext_addr);
		chk("sda10", 1'b1, sdram_addr10_pin);
		chk("cs", 8'hFD, chip_select_lines_n);
		chk("oe", 32'hFFFFFFFF, ext_data_oe);
		chk("dout", 32'h9ABCDEF0, ext_data_out);
		chk("wait", 1'b1, ctrl_wait_n);
		// Reset again in mid access; release lands on a rising edge
		@(posedge sys_clk);
		resetn <= 1'b0;
		wait_cyc(2);
		chk("cs", 8'hFF, chip_select_lines_n);
		@(posedge sys_clk);
		resetn <= 1'b1;
		reg_read(OFS, `EBPM_CFG_RESET);
		chk("cs", 8'hFF, chip_select_lines_n);
		test_done();
	end
endmodule
